// ==== src/dcfc_top.sv ====
`timescale 1ns/100ps
// Functional notes
// RULE1 - Full clear zeroes both pointers, almost-empty low, almost-full and half high.
// RULE2 - Mode pin low at full clear: standard mode, empty low, full high.
// RULE3 - Mode pin high at full clear: fall-through, output-ready high, input-ready low.
// RULE4 - Load pin low at full clear: offsets 127, parallel writing only.
// RULE5 - Load pin high at full clear: offsets 1023, serial loading only.
// RULE6 - Offset registers read back on data out in either method.
// RULE7 - Full clear zeroes output register; writer clears once after power-up.
// RULE8 - Partial clear zeroes pointers, almost-empty low, almost-full and half high.
// RULE9 - Partial clear keeps mode and drives its idle flag levels.
// RULE10 - Partial clear keeps offsets and method, zeroes output register.
// RULE11 - Replay low at read edge restarts read pointer at location zero.
// RULE12 - Reader and writer hold both enables high before lowering replay.
// RULE13 - Standard replay: empty low during setup, high after; each word needs enable.
// RULE14 - Fall-through replay: output-ready high, then low with first word shown.
// RULE15 - Standard mode delivers each word only on an enabled read edge.
// RULE16 - Fall-through shows first word after three read edges, later ones need enable.
// RULE17 - After full clear mode pin is serial offset input, serial method only.
// RULE18 - Enabled write edge stores one word when not full; disabled stores nothing.
// RULE19 - Write-side flags change only on write edges; writes only lower half flag.
// RULE20 - Standard full flag low when full, rises two write edges after read.
// RULE21 - Input-ready high when full, falls two write edges after read.
// RULE22 - Write enable ignored while full.
// RULE23 - Read-side flags change only on read edges; reads only raise half flag.
// RULE24 - Writer stores between one and depth minus two words before replay.
// RULE25 - Read enable ignored while empty; output register holds otherwise.
module dcfc_top #(
	parameter int DEPTH  = dcfc_pkg::DCFC_DEPTH,
	parameter int DATA_W = dcfc_pkg::DCFC_DATA_W
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire logic                   wclk_i,
	input  wire logic                   rclk_i,
	input  wire logic                   write_en_n_i,
	input  wire logic                   read_en_n_i,
	input  wire logic                   replay_n_i,
	input  wire logic                   mode_sel_serial_in_i,
	input  wire logic                   offset_load_n_i,
	input  wire logic                   serial_en_n_i,
	input  wire logic                   full_clear_n_i,
	input  wire logic                   partial_clear_n_i,
	input  wire logic [DATA_W-1:0]      data_in_i,
	output logic      [DATA_W-1:0]      data_out_o,
	output dcfc_pkg::dcfc_flags_s       flags_o,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [3:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o
);

	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam int OW = dcfc_pkg::DCFC_OFS_W;
	localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
	localparam logic [PW-1:0] HALF_P  = PW'(DEPTH / 2);

	// ==========================================================
	// Pin synchronisers; stage one feeds only stage two
	dcfc_pkg::dcfc_pins_s pin_raw;
	dcfc_pkg::dcfc_pins_s pin_s1_r;
	dcfc_pkg::dcfc_pins_s pin_r;
	logic                 wclk_d_r;
	logic                 rclk_d_r;

	assign pin_raw = '{wclk: wclk_i, rclk: rclk_i, write_en_n: write_en_n_i,
		read_en_n: read_en_n_i, replay_n: replay_n_i,
		mode_sel_serial_in: mode_sel_serial_in_i, offset_load_n: offset_load_n_i,
		serial_en_n: serial_en_n_i, full_clear_n: full_clear_n_i,
		partial_clear_n: partial_clear_n_i, data_in: data_in_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_s1_r <= '0;
			pin_r    <= '0;
			wclk_d_r <= 1'b0;
			rclk_d_r <= 1'b0;
		end else if (ce_i) begin
			pin_s1_r <= pin_raw;
			pin_r    <= pin_s1_r;
			wclk_d_r <= pin_r.wclk;
			rclk_d_r <= pin_r.rclk;
		end
	end

	// ==========================================================
	// Events and clears
	logic             wr_edge;
	logic             rd_edge;
	logic             fclr;
	logic             clr;
	logic [1:0]       ctrl_r;
	logic             fall_through_mode;
	logic             serial_method_r;
	logic [OW-1:0]    empty_ofs_r;
	logic [OW-1:0]    full_ofs_r;

	// Clock pins carry no reset state: idle clock means no edge, so flags freeze
	assign wr_edge = ce_i && pin_r.wclk && !wclk_d_r;                       // RULE19
	assign rd_edge = ce_i && pin_r.rclk && !rclk_d_r;                       // RULE23
	assign fclr    = !pin_r.full_clear_n;
	// Clears act on the level, without waiting for any link clock edge
	assign clr     = fclr || !pin_r.partial_clear_n || ctrl_r[dcfc_pkg::DCFC_CTRL_PCLR];

	// ==========================================================
	// Mode and method, caught while full clear is held
	logic fall_through_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fall_through_r  <= 1'b0;
			serial_method_r <= 1'b0;
		end else if (ce_i && fclr) begin
			fall_through_r  <= pin_r.mode_sel_serial_in;                   // RULE2 RULE3
			serial_method_r <= pin_r.offset_load_n;                        // RULE4 RULE5
		end
	end

	// Partial clear leaves both latched choices alone
	assign fall_through_mode = fall_through_r;                          // RULE9

	// ==========================================================
	// Offset registers
	logic ofs_wsel_r;
	logic ofs_load_par;
	logic ofs_load_ser;

	assign ofs_load_par = wr_edge && !fclr && !pin_r.offset_load_n && !serial_method_r
		&& !pin_r.write_en_n;                                               // RULE4
	assign ofs_load_ser = wr_edge && !fclr && !pin_r.offset_load_n && serial_method_r
		&& !pin_r.serial_en_n;                                              // RULE5 RULE17

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			empty_ofs_r <= dcfc_pkg::DCFC_OFS_DEF_PAR;
			full_ofs_r  <= dcfc_pkg::DCFC_OFS_DEF_PAR;
			ofs_wsel_r  <= 1'b0;
		end else if (ce_i && fclr) begin
			empty_ofs_r <= pin_r.offset_load_n ? dcfc_pkg::DCFC_OFS_DEF_SER
				: dcfc_pkg::DCFC_OFS_DEF_PAR;                               // RULE4 RULE5
			full_ofs_r  <= pin_r.offset_load_n ? dcfc_pkg::DCFC_OFS_DEF_SER
				: dcfc_pkg::DCFC_OFS_DEF_PAR;
			ofs_wsel_r  <= 1'b0;
		end else if (ofs_load_par) begin
			if (ofs_wsel_r) begin
				full_ofs_r <= OW'(pin_r.data_in);
			end else begin
				empty_ofs_r <= OW'(pin_r.data_in);
			end
			ofs_wsel_r <= !ofs_wsel_r;
		end else if (ofs_load_ser) begin
			// Shifted in at the top, empty offset fills first
			{full_ofs_r, empty_ofs_r} <= {pin_r.mode_sel_serial_in, full_ofs_r,
				empty_ofs_r[OW-1:1]};                                        // RULE17
		end
	end

	// ==========================================================
	// Storage and write side
	logic [DATA_W-1:0] mem_r [DEPTH];
	logic [PW-1:0]     wptr_r;
	logic [PW-1:0]     wptr_nxt;
	logic [PW-1:0]     rptr_r;
	logic [PW-1:0]     rptr_ws_r;
	logic              full_r;
	logic              af_n_r;
	logic              wr_go;

	assign wr_go = wr_edge && !clr && !pin_r.write_en_n && pin_r.offset_load_n
		&& !full_r && !ctrl_r[dcfc_pkg::DCFC_CTRL_BLOCK];                    // RULE18 RULE22
	assign wptr_nxt = wr_go ? wptr_r + PW'(1) : wptr_r;

	always_ff @(posedge clk_i) begin
		if (ce_i && wr_go) begin
			mem_r[wptr_r[AW-1:0]] <= pin_r.data_in;                         // RULE18
		end
	end

	// One resync stage plus the flag stage gives the two write edges
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && clr)) begin
			wptr_r    <= '0;                                                // RULE1 RULE8
			rptr_ws_r <= '0;
			full_r    <= 1'b0;
			af_n_r    <= 1'b1;
		end else if (wr_edge) begin
			wptr_r    <= wptr_nxt;
			rptr_ws_r <= rptr_r;
			full_r    <= (wptr_nxt - rptr_ws_r) == DEPTH_P;                  // RULE20 RULE21
			af_n_r    <= (wptr_nxt - rptr_ws_r) < (DEPTH_P - PW'(full_ofs_r));
		end
	end

	// ==========================================================
	// Read side
	dcfc_pkg::dcfc_replay_e replay_st_r;
	logic [PW-1:0]          wptr_rs_r;
	logic [PW-1:0]          rptr_nxt;
	logic                   mem_empty_r;
	logic                   out_valid_r;
	logic                   ae_n_r;
	logic                   ofs_rsel_r;
	logic                   ofs_rd;
	logic                   replay_go;
	logic                   rd_go;
	logic                   fall_through_mode_load;
	logic                   fall_through_mode_drop;
	logic                   mem_has;
	dcfc_pkg::dcfc_replay_e replay_st_nxt;

	assign ofs_rd    = rd_edge && !pin_r.offset_load_n && !pin_r.read_en_n; // RULE6
	assign replay_go = rd_edge && !clr && !pin_r.replay_n;                  // RULE11 RULE12
	assign rd_go     = rd_edge && !clr && pin_r.replay_n && pin_r.offset_load_n
		&& replay_st_r == dcfc_pkg::DCFC_RP_IDLE && !mem_empty_r
		&& !fall_through_mode && !pin_r.read_en_n;                          // RULE15 RULE25
	// Setup holds the empty state, so the completing edge looks at the pointers
	assign mem_has   = (replay_st_r == dcfc_pkg::DCFC_RP_SETUP) ? (rptr_r != wptr_rs_r)
		: !mem_empty_r;
	assign fall_through_mode_load = rd_edge && !clr && pin_r.replay_n && pin_r.offset_load_n
		&& mem_has
		&& fall_through_mode && (!out_valid_r || !pin_r.read_en_n);         // RULE14 RULE16
	assign fall_through_mode_drop = rd_edge && !clr && pin_r.replay_n && pin_r.offset_load_n
		&& fall_through_mode && out_valid_r && !pin_r.read_en_n && !fall_through_mode_load;
	assign rptr_nxt  = (rd_go || fall_through_mode_load) ? rptr_r + PW'(1) : rptr_r;

	// ==========================================================
	// Replay sequencing
	always_comb begin
		replay_st_nxt = replay_st_r;
		case (replay_st_r)
			dcfc_pkg::DCFC_RP_IDLE: begin
				if (replay_go) begin
					replay_st_nxt = dcfc_pkg::DCFC_RP_SETUP;                // RULE11
				end
			end
			dcfc_pkg::DCFC_RP_SETUP: begin
				// Replay still held low simply restarts setup
				if (rd_edge && !replay_go) begin
					replay_st_nxt = dcfc_pkg::DCFC_RP_IDLE;                 // RULE13 RULE14
				end
			end
			default: begin
				replay_st_nxt = dcfc_pkg::DCFC_RP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && clr)) begin
			replay_st_r <= dcfc_pkg::DCFC_RP_IDLE;
		end else if (ce_i) begin
			replay_st_r <= replay_st_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && clr)) begin
			rptr_r      <= '0;                                              // RULE1 RULE8
			wptr_rs_r   <= '0;
			mem_empty_r <= 1'b1;
			out_valid_r <= 1'b0;                                            // RULE2 RULE3
			ae_n_r      <= 1'b0;
		end else if (replay_go) begin
			// Setup edge: empty shows low, output-ready shows high
			rptr_r      <= '0;                                              // RULE11
			mem_empty_r <= 1'b1;                                            // RULE13
			out_valid_r <= 1'b0;                                            // RULE14
		end else if (rd_edge) begin
			rptr_r      <= rptr_nxt;
			wptr_rs_r   <= wptr_r;
			mem_empty_r <= rptr_nxt == wptr_rs_r;                           // RULE13 RULE25
			ae_n_r      <= (wptr_rs_r - rptr_nxt) > PW'(empty_ofs_r);
			if (fall_through_mode_load) begin
				out_valid_r <= 1'b1;                                        // RULE14 RULE16
			end else if (fall_through_mode_drop) begin
				out_valid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && fclr)) begin
			ofs_rsel_r <= 1'b0;
		end else if (ofs_rd) begin
			ofs_rsel_r <= !ofs_rsel_r;
		end
	end

	// Offset read-back overwrites whatever word sat on the outputs
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && clr)) begin
			data_out_o <= dcfc_pkg::DCFC_DOUT_RST;                          // RULE7 RULE10
		end else if (ofs_rd) begin
			data_out_o <= DATA_W'(ofs_rsel_r ? full_ofs_r : empty_ofs_r);   // RULE6
		end else if (rd_go || fall_through_mode_load) begin
			data_out_o <= mem_r[rptr_r[AW-1:0]];                            // RULE15 RULE16
		end
	end

	// ==========================================================
	// Half level and flag pins
	logic hf_n_r;

	// Level drawn from live pointers: writes and replays can only lower it, reads only raise it
	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && clr)) begin
			hf_n_r <= 1'b1;                                                 // RULE1 RULE8
		end else if (ce_i) begin
			hf_n_r <= !((wptr_r - rptr_r) > HALF_P);                        // RULE19 RULE23
		end
	end

	assign flags_o.half_level_flag_n   = hf_n_r;
	assign flags_o.almost_full_flag_n  = af_n_r;
	assign flags_o.almost_empty_flag_n = ae_n_r;
	assign flags_o.full_ir_n   = fall_through_mode ? full_r : !full_r;      // RULE20 RULE21
	assign flags_o.empty_or_n  = fall_through_mode ? !out_valid_r : !mem_empty_r;

	// ==========================================================
	// Wishbone slave, one wait state, unmapped reads as zero
	logic        wb_req;
	logic [31:0] rd_word;

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_comb begin
		rd_word = 32'h00000000;
		case (wb_adr_i)
			dcfc_pkg::DCFC_REG_STATUS: begin
				rd_word[dcfc_pkg::DCFC_ST_FLAGS +: 5] = flags_o;
				rd_word[dcfc_pkg::DCFC_ST_MODE]       = fall_through_mode;
				rd_word[dcfc_pkg::DCFC_ST_SERIAL]     = serial_method_r;
				rd_word[dcfc_pkg::DCFC_ST_REPLAY]     = replay_st_r == dcfc_pkg::DCFC_RP_SETUP;
			end
			dcfc_pkg::DCFC_REG_LEVEL: begin
				rd_word[PW-1:0] = wptr_r - rptr_r;
			end
			dcfc_pkg::DCFC_REG_OFFS: begin
				rd_word[OW-1:0] = empty_ofs_r;
				rd_word[dcfc_pkg::DCFC_OFS_FULL_LO +: OW] = full_ofs_r;
			end
			dcfc_pkg::DCFC_REG_CTRL: begin
				rd_word[1:0] = ctrl_r;
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= rd_word;
			end
		end
	end

	// Soft partial clear lasts one cycle; block bit drops writes while set, the words are lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= dcfc_pkg::DCFC_CTRL_RST;
		end else if (ce_i) begin
			ctrl_r[dcfc_pkg::DCFC_CTRL_PCLR] <= 1'b0;
			if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == dcfc_pkg::DCFC_REG_CTRL) begin
				ctrl_r <= wb_dat_i[1:0];
			end
		end
	end

endmodule : dcfc_top

// ==== src/dcfc_pkg.sv ====
package dcfc_pkg;

	// ==========================================================
	// Data path and memory
	localparam int DCFC_DATA_W      = 18;
	localparam int DCFC_DEPTH       = 8192;
	localparam int DCFC_OFS_W       = 16;

	// ==========================================================
	// Values after full clear; control register value after reset
	localparam logic [DCFC_OFS_W-1:0] DCFC_OFS_DEF_PAR = 16'h007f;
	localparam logic [DCFC_OFS_W-1:0] DCFC_OFS_DEF_SER = 16'h03ff;
	localparam logic [DCFC_DATA_W-1:0] DCFC_DOUT_RST   = 18'h00000;
	localparam logic [1:0]            DCFC_CTRL_RST    = 2'h0;

	// ==========================================================
	// Cycle counts, in edges of the clock that owns the flag
	localparam int DCFC_FULL_EDGES  = 2;
	localparam int DCFC_EMPTY_EDGES = 2;
	localparam int DCFC_FALL_THROUGH_MODE_EDGES  = 3;

	// ==========================================================
	// Wishbone byte offsets
	localparam logic [3:0] DCFC_REG_STATUS = 4'h0;
	localparam logic [3:0] DCFC_REG_LEVEL  = 4'h4;
	localparam logic [3:0] DCFC_REG_OFFS   = 4'h8;
	localparam logic [3:0] DCFC_REG_CTRL   = 4'hc;

	// ==========================================================
	// Field positions
	localparam int DCFC_ST_FLAGS    = 0;
	localparam int DCFC_ST_MODE     = 5;
	localparam int DCFC_ST_SERIAL   = 6;
	localparam int DCFC_ST_REPLAY   = 7;
	localparam int DCFC_CTRL_BLOCK  = 0;
	localparam int DCFC_CTRL_PCLR   = 1;
	localparam int DCFC_OFS_FULL_LO = 16;

	// ==========================================================
	// Types
	typedef struct packed {
		logic half_level_flag_n;
		logic almost_full_flag_n;
		logic almost_empty_flag_n;
		logic full_ir_n;
		logic empty_or_n;
	} dcfc_flags_s;

	typedef struct packed {
		logic                   wclk;
		logic                   rclk;
		logic                   write_en_n;
		logic                   read_en_n;
		logic                   replay_n;
		logic                   mode_sel_serial_in;
		logic                   offset_load_n;
		logic                   serial_en_n;
		logic                   full_clear_n;
		logic                   partial_clear_n;
		logic [DCFC_DATA_W-1:0] data_in;
	} dcfc_pins_s;

	typedef enum logic [1:0] {
		DCFC_RP_IDLE  = 2'b01,
		DCFC_RP_SETUP = 2'b10
	} dcfc_replay_e;

endpackage : dcfc_pkg

// ==== verif/dcfc_top_properties.sv ====
`timescale 1ns/100ps
module dcfc_top_chk #(
	parameter int DEPTH  = dcfc_pkg::DCFC_DEPTH,
	parameter int DATA_W = dcfc_pkg::DCFC_DATA_W
) (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  wclk_i,
	input wire logic                  rclk_i,
	input wire logic                  full_clear_n_i,
	input wire logic                  partial_clear_n_i,
	input wire logic [DATA_W-1:0]     data_out_o,
	input wire dcfc_pkg::dcfc_flags_s flags_o,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_ack_o
);
	// ==========================================================
	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Pin edges land a few cycles late, so look back over a short span
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_clr_flags: assert property (!full_clear_n_i [*4] |-> !flags_o.almost_empty_flag_n && flags_o.almost_full_flag_n && flags_o.half_level_flag_n)
		else $error("full clear flag levels wrong");
	a_clr_dout: assert property (!full_clear_n_i [*4] |-> data_out_o == '0)
		else $error("full clear left output register set");
	a_pclr_state: assert property (!partial_clear_n_i [*4] |-> data_out_o == '0 && !flags_o.almost_empty_flag_n && flags_o.half_level_flag_n)
		else $error("partial clear state wrong");
	a_dout_rclk: assert property (disable iff (rst_i || !full_clear_n_i || !partial_clear_n_i) $changed(data_out_o) |-> $past(rclk_i, 2) || $past(rclk_i, 3) || $past(rclk_i, 4))
		else $error("output register moved without read edge");
	a_or_rclk: assert property (disable iff (rst_i || !full_clear_n_i || !partial_clear_n_i) $changed(flags_o.empty_or_n) |-> $past(rclk_i, 2) || $past(rclk_i, 3) || $past(rclk_i, 4))
		else $error("empty flag moved without read edge");
	a_ir_wclk: assert property (disable iff (rst_i || !full_clear_n_i || !partial_clear_n_i) $changed(flags_o.full_ir_n) |-> $past(wclk_i, 2) || $past(wclk_i, 3) || $past(wclk_i, 4))
		else $error("full flag moved without write edge");
	c_clear: cover property (!full_clear_n_i [*4]);
	c_full: cover property ($fell(flags_o.full_ir_n));
	c_room: cover property ($rose(flags_o.full_ir_n));
endmodule : dcfc_top_chk
bind dcfc_top dcfc_top_chk #(.DEPTH(DEPTH), .DATA_W(DATA_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wclk_i(wclk_i), .rclk_i(rclk_i), .full_clear_n_i(full_clear_n_i),
	.partial_clear_n_i(partial_clear_n_i), .data_out_o(data_out_o), .flags_o(flags_o),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// ==== verif/dcfc_far_end.sv ====
`timescale 1ns/100ps
module dcfc_far_end (
	input  wire logic                           clk_i,
	output logic                                wclk_o,
	output logic                                rclk_o,
	output logic                                write_en_n_o,
	output logic                                read_en_n_o,
	output logic                                replay_n_o,
	output logic [dcfc_pkg::DCFC_DATA_W-1:0]    data_in_o
);
	// Phase above the two cycle minimum of the pin sampler
	localparam int HOLD = 4;
	initial begin
		wclk_o = 1'b0;
		rclk_o = 1'b0;
		write_en_n_o = 1'b1;
		read_en_n_o = 1'b1;
		replay_n_o = 1'b1;
		data_in_o = '0;
	end
	// Pin clocks stand still between transfers
	task automatic pulse(input logic is_w);
		@(posedge clk_i);
		if (is_w) wclk_o <= 1'b1;
		else rclk_o <= 1'b1;
		repeat (HOLD) @(posedge clk_i);
		wclk_o <= 1'b0;
		rclk_o <= 1'b0;
		repeat (HOLD) @(posedge clk_i);
	endtask : pulse
	task automatic w_edge(input logic en_n, input logic [dcfc_pkg::DCFC_DATA_W-1:0] d);
		@(posedge clk_i);
		write_en_n_o <= en_n;
		data_in_o <= d;
		pulse(1'b1);
		write_en_n_o <= 1'b1;
		data_in_o <= ~d;
	endtask : w_edge
	task automatic r_edge(input logic en_n, input logic rt_n);
		@(posedge clk_i);
		read_en_n_o <= en_n | ~rt_n;
		replay_n_o <= rt_n;
		pulse(1'b0);
		read_en_n_o <= 1'b1;
		replay_n_o <= 1'b1;
	endtask : r_edge
endmodule : dcfc_far_end

// ==== verif/tb_dcfc_top.sv ====
`timescale 1ns/100ps
module tb_dcfc_top;
	localparam int DEPTH = 16;
	localparam logic [31:0] SER_PAT = 32'h01234567;
	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic                  mode_sel = 1'b0;
	logic                  load_n = 1'b0;
	logic                  fclr_n = 1'b1;
	logic                  pclr_n = 1'b1;
	logic                  serial_en_n = 1'b1;
	logic                  wb_cyc = 1'b0;
	logic                  wb_stb = 1'b0;
	logic                  wb_we = 1'b0;
	logic [3:0]            wb_adr = 4'h0;
	logic [31:0]           wb_wdat = 32'h0;
	logic [31:0]           wb_rdat;
	logic [31:0]           rd;
	logic                  ack;
	logic                  wclk, rclk, wen_n, ren_n, rt_n;
	logic [17:0]           din, dout;
	dcfc_pkg::dcfc_flags_s flags;
	int                    mismatches = 0;
	int                    check_count = 0;
	int                    cyc_cnt = 0;
	always #5 clk_i = ~clk_i;
	dcfc_far_end far (.clk_i(clk_i), .wclk_o(wclk), .rclk_o(rclk), .write_en_n_o(wen_n),
		.read_en_n_o(ren_n), .replay_n_o(rt_n), .data_in_o(din));
	dcfc_top #(.DEPTH(DEPTH)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wclk_i(wclk),
		.rclk_i(rclk), .write_en_n_i(wen_n), .read_en_n_i(ren_n), .replay_n_i(rt_n),
		.mode_sel_serial_in_i(mode_sel), .offset_load_n_i(load_n), .serial_en_n_i(serial_en_n),
		.full_clear_n_i(fclr_n), .partial_clear_n_i(pclr_n), .data_in_i(din),
		.data_out_o(dout), .flags_o(flags), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(ack));
	// ==========================================================
	// Tasks
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_wdat <= wd;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	task automatic chk_reg(input logic [3:0] adr, input logic [31:0] e);
		wb(1'b0, adr, 32'h0);
		check_count++;
		if (rd !== e) begin
			mismatches++;
			$display("ERROR %0t reg %h got %h exp %h", $time, adr, rd, e);
		end
	endtask : chk_reg
	task automatic chk_flag(input logic [4:0] m, input logic [4:0] e);
		check_count++;
		if ((flags & m) !== e) begin
			mismatches++;
			$display("ERROR %0t flags %b exp %b", $time, flags & m, e);
		end
	endtask : chk_flag
	task automatic chk_data(input logic [17:0] e);
		check_count++;
		if (dout !== e) begin
			mismatches++;
			$display("ERROR %0t data %h exp %h", $time, dout, e);
		end
	endtask : chk_data
	task automatic fclr(input logic m, input logic l);
		@(posedge clk_i);
		mode_sel <= m;
		load_n <= l;
		fclr_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		fclr_n <= 1'b1;
		repeat (4) @(posedge clk_i);
		mode_sel <= 1'b0;
		load_n <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask : fclr
	// ==========================================================
	// Tests
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		fclr(1'b0, 1'b0);
		chk_flag(5'h1f, 5'h1a);
		chk_data(18'h0);
		chk_reg(dcfc_pkg::DCFC_REG_OFFS, 32'h007f007f);
		chk_reg(dcfc_pkg::DCFC_REG_STATUS, 32'h0000001a);
		chk_reg(4'h2, 32'h0);
		$display("test 1 done");
		far.w_edge(1'b0, 18'h2a5a5);
		far.w_edge(1'b0, 18'h15a5a);
		far.r_edge(1'b1, 1'b1);
		far.r_edge(1'b1, 1'b1);
		chk_flag(5'h1f, 5'h1b);
		far.r_edge(1'b0, 1'b1);
		chk_data(18'h2a5a5);
		far.r_edge(1'b1, 1'b0);
		chk_flag(5'h01, 5'h00);
		far.r_edge(1'b1, 1'b1);
		chk_flag(5'h01, 5'h01);
		far.r_edge(1'b0, 1'b1);
		chk_data(18'h2a5a5);
		far.r_edge(1'b0, 1'b1);
		far.r_edge(1'b0, 1'b1);
		chk_data(18'h15a5a);
		wb(1'b1, dcfc_pkg::DCFC_REG_CTRL, 32'h1);
		far.w_edge(1'b0, 18'h00003);
		chk_reg(dcfc_pkg::DCFC_REG_LEVEL, 32'h0);
		wb(1'b1, dcfc_pkg::DCFC_REG_CTRL, 32'h0);
		$display("test 2 done");
		for (int i = 0; i < DEPTH; i++) far.w_edge(1'b0, 18'(i));
		chk_flag(5'h02, 5'h00);
		far.w_edge(1'b0, 18'h3ffff);
		chk_reg(dcfc_pkg::DCFC_REG_LEVEL, 32'(DEPTH));
		repeat (2) far.r_edge(1'b1, 1'b1);
		far.r_edge(1'b0, 1'b1);
		chk_data(18'h0);
		far.w_edge(1'b1, 18'h0);
		chk_flag(5'h02, 5'h00);
		far.w_edge(1'b1, 18'h0);
		chk_flag(5'h02, 5'h02);
		pclr_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk_flag(5'h1f, 5'h1a);
		chk_data(18'h0);
		pclr_n <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk_reg(dcfc_pkg::DCFC_REG_OFFS, 32'h007f007f);
		$display("test 3 done");
		fclr(1'b1, 1'b1);
		chk_flag(5'h1f, 5'h19);
		chk_reg(dcfc_pkg::DCFC_REG_OFFS, 32'h03ff03ff);
		chk_reg(dcfc_pkg::DCFC_REG_STATUS, 32'h00000079);
		load_n <= 1'b0;
		serial_en_n <= 1'b0;
		for (int i = 0; i < 32; i++) begin
			mode_sel <= SER_PAT[i];
			far.w_edge(1'b1, 18'h00000);
		end
		serial_en_n <= 1'b1;
		far.w_edge(1'b0, 18'h3ffff);
		chk_reg(dcfc_pkg::DCFC_REG_OFFS, SER_PAT);
		far.r_edge(1'b0, 1'b1);
		chk_data(18'h04567);
		far.r_edge(1'b0, 1'b1);
		chk_data(18'h00123);
		load_n <= 1'b1;
		mode_sel <= 1'b0;
		far.w_edge(1'b0, 18'h0c3c3);
		repeat (3) far.r_edge(1'b1, 1'b1);
		chk_data(18'h0c3c3);
		chk_flag(5'h01, 5'h00);
		far.r_edge(1'b1, 1'b0);
		chk_flag(5'h01, 5'h01);
		far.r_edge(1'b1, 1'b1);
		chk_data(18'h0c3c3);
		chk_flag(5'h01, 5'h00);
		$display("test 4 done");
		wrap_up();
	end
endmodule : tb_dcfc_top
